// File: core/rsw_consts.svh
/*
 * constants for the reset, stop and wait sequencer: timing counts,
 * field positions and mode select values.
 * assumes a core clock of 200 MHz and an external clock of 8 MHz.
 */
`ifndef RSW_CONSTS_SVH
`define RSW_CONSTS_SVH

// clock periods in picoseconds
`define RSW_CLK_PS          5000
`define RSW_EXT_CLK_PS      125000

// latest first bus address after reset release, core cycles (120)
`define RSW_FIRST_ADDR_MAX  8'h78

// interrupt to first service access, core cycles (18 / 14)
`define RSW_SVC_NORM        5'h12
`define RSW_SVC_FAST        5'h0e

// wait wake to first vector address, core cycles (22 / 18)
`define RSW_VEC_NORM        5'h16
`define RSW_VEC_FAST        5'h12

// wait wake to first data access: fast in core cycles (18),
// normal in external clock periods (22)
`define RSW_WDM_FAST        5'h12
`define RSW_WDM_NORM_ET     8'h16

// stop wake to first data access, in half core cycles (1.5 cycles)
`define RSW_STOP_WAKE_HALF  5'h03

// reset output pulse, external clock periods (128 / 8)
`define RSW_RESET_OUT_PULSE_NORM_ET    8'h80
`define RSW_RESET_OUT_PULSE_INT_ET     8'h08

// fast stop recovery bit of the operating mode register
`define RSW_OMR_FAST_BIT    6

// mode select value that shows interrupt fetches on the pins
`define RSW_MODE_PIN_FETCH  2'h3

`endif

// File: core/rsw_et_tick.sv
/*
 * external clock period divider: one tick per external period.
 * assumes the core clock is an integer multiple of the external clock.
 */
`timescale 1ns/10ps
`include "rsw_consts.svh"

module rsw_et_tick
   import rsw_pkg::*;
#(
   parameter int DIV = `RSW_EXT_CLK_PS / `RSW_CLK_PS
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic restart_i,
   output logic      tick_o
);

   localparam logic [15:0] LAST = 16'(DIV - 1);

   rsw_tick_st_t s_r;
   rsw_tick_st_t s_nxt;

   ////////////////////////////////////////////////////////////////////////
   // period count, restart aligns the first full period
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (restart_i) begin
         s_nxt.cnt = 16'h0000;
      end else if (s_r.cnt == LAST) begin
         s_nxt.cnt = 16'h0000;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick_o = s_r.tick;

endmodule

// File: core/rsw_pkg.sv
/*
 * types of the reset, stop and wait sequencer.
 * assumes nothing beyond a systemverilog compiler.
 */
package rsw_pkg;

   // sequencer states
   typedef enum logic [2:0] {
      rsw_st_reset,
      rsw_st_boot,
      rsw_st_run,
      rsw_st_wait,
      rsw_st_wake_w,
      rsw_st_stop,
      rsw_st_wake_s
   } rsw_state_t;

   // whole state of the sequencer
   typedef struct packed {
      rsw_state_t  st;
      logic [4:0]  cnt;
      logic [7:0]  et_cnt;
      logic [4:0]  svc_cnt;
      logic        svc_busy;
      logic        fast;
      logic        vec_done;
      logic        dm_done;
      logic        irq1_q;
      logic        irq2_q;
      logic        core_rst;
      logic        reset_out_pulse_n;
      logic        pll_en;
      logic        pll_byp;
      logic        mclk_en;
      logic        first_addr;
      logic        svc_ok;
      logic        vec_fetch;
      logic        vec_pin;
      logic        dm_ok;
      logic        fetch_vis;
   } rsw_seq_st_t;

   // whole state of the external clock period divider
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } rsw_tick_st_t;

endpackage

// File: core/rsw_seq.sv
/*
 * reset, stop, wait and interrupt wake sequencer of the core.
 * assumes all inputs synchronous to clk_i; interrupt and board reset
 * lines are active low; the external clock is a fixed multiple.
 */
`timescale 1ns/10ps
`include "rsw_consts.svh"

module rsw_seq
   import rsw_pkg::*;
#(
   parameter logic [7:0] FIRST_ADDR_CYC = 8'h10,
   parameter int         EXT_DIV        = `RSW_EXT_CLK_PS / `RSW_CLK_PS
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        board_reset_n_i,
   input  wire logic        internal_reset_mode_i,
   input  wire logic        ext_irq_first_n_i,
   input  wire logic        ext_irq_second_n_i,
   input  wire logic        stop_req_i,
   input  wire logic        wait_req_i,
   input  wire logic        pll_on_req_i,
   input  wire logic        ext_clk_direct_i,
   input  wire logic [15:0] operating_mode_reg_i,
   input  wire logic [1:0]  mode_sel_i,
   output logic             core_reset_o,
   output logic             reset_out_pulse_n_o,
   output logic             pll_enable_o,
   output logic             pll_bypass_o,
   output logic             master_clk_en_o,
   output logic             first_addr_o,
   output logic             svc_access_ok_o,
   output logic             vector_fetch_o,
   output logic             vector_pin_o,
   output logic             data_access_ok_o,
   output logic             fetch_visible_o
);

   localparam logic [4:0] STOP_WAKE_CYC = (`RSW_STOP_WAKE_HALF + 5'h01) >> 1;

   localparam rsw_seq_st_t RESET_VAL = '{
      st: rsw_st_reset, irq1_q: 1'b1, irq2_q: 1'b1, core_rst: 1'b1,
      pll_byp: 1'b1, mclk_en: 1'b1, default: '0};

   rsw_seq_st_t s_r;
   rsw_seq_st_t s_nxt;
   logic        et_tick;
   logic        rst_req;
   logic        enter_rst;
   logic        irq1_fall;
   logic        irq2_fall;
   logic        fast_sel;
   logic [7:0]  reset_out_pulse_len;

   // picks the fast or the normal figure of a latency
   function automatic logic [4:0] pick(input logic       f,
                                       input logic [4:0] fast_v,
                                       input logic [4:0] norm_v);
      pick = f ? fast_v : norm_v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // request decode
   assign rst_req   = !board_reset_n_i;
   assign enter_rst = rst_req && (s_r.st != rsw_st_reset);
   assign irq1_fall = s_r.irq1_q && !ext_irq_first_n_i;
   assign irq2_fall = s_r.irq2_q && !ext_irq_second_n_i;
   assign fast_sel  = ext_clk_direct_i
                    || operating_mode_reg_i[`RSW_OMR_FAST_BIT];
   assign reset_out_pulse_len  = internal_reset_mode_i ? `RSW_RESET_OUT_PULSE_INT_ET
                                            : `RSW_RESET_OUT_PULSE_NORM_ET;

   // external period ticks, realigned whenever reset is entered
   rsw_et_tick #(
      .DIV       (EXT_DIV)
   ) u_et_tick (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .restart_i (enter_rst),
      .tick_o    (et_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.irq1_q = ext_irq_first_n_i;
      s_nxt.irq2_q = ext_irq_second_n_i;
      s_nxt.first_addr = 1'b0;
      s_nxt.svc_ok = 1'b0;
      s_nxt.vec_fetch = 1'b0;
      s_nxt.vec_pin = 1'b0;
      s_nxt.dm_ok = 1'b0;
      // pin visibility only in mode 3
      s_nxt.fetch_vis = (mode_sel_i == `RSW_MODE_PIN_FETCH);
      // service latency counter, armed by an edge in run
      if (s_r.svc_busy) begin
         if (s_r.svc_cnt == pick(fast_sel, `RSW_SVC_FAST, `RSW_SVC_NORM)) begin
            s_nxt.svc_ok = 1'b1;
            s_nxt.svc_busy = 1'b0;
         end else begin
            s_nxt.svc_cnt = s_r.svc_cnt + 5'h01;
         end
      end else if (s_r.st == rsw_st_run && (irq1_fall || irq2_fall)) begin
         s_nxt.svc_busy = 1'b1;
         s_nxt.svc_cnt = 5'h01;
      end
      if (enter_rst) begin
         // reset taken on the first edge it is seen
         s_nxt = RESET_VAL;
         s_nxt.irq1_q = ext_irq_first_n_i;
         s_nxt.irq2_q = ext_irq_second_n_i;
      end else begin
         case (s_r.st)
            rsw_st_reset: begin
               // pll off and bypassed, core on source clock
               s_nxt.pll_en = 1'b0;
               s_nxt.pll_byp = 1'b1;
               s_nxt.mclk_en = 1'b1;
               s_nxt.svc_busy = 1'b0;
               // reset output held for the full count
               if (et_tick && s_r.et_cnt != reset_out_pulse_len) begin
                  s_nxt.et_cnt = s_r.et_cnt + 8'h01;
               end
               if (!rst_req && s_r.et_cnt == reset_out_pulse_len) begin
                  s_nxt.st = rsw_st_boot;
                  s_nxt.core_rst = 1'b0;
                  s_nxt.reset_out_pulse_n = 1'b1;
                  s_nxt.cnt = 5'h00;
                  s_nxt.et_cnt = 8'h00;
               end
            end
            rsw_st_boot: begin
               // first address well inside the limit
               if ({3'h0, s_r.cnt} == FIRST_ADDR_CYC) begin
                  s_nxt.first_addr = 1'b1;
                  s_nxt.st = rsw_st_run;
               end else begin
                  s_nxt.cnt = s_r.cnt + 5'h01;
               end
            end
            rsw_st_run: begin
               s_nxt.pll_en = pll_on_req_i;
               s_nxt.pll_byp = !pll_on_req_i;
               if (stop_req_i) begin
                  s_nxt.st = rsw_st_stop;
                  s_nxt.fast = fast_sel;
                  // normal stop drops pll and master clock on the same edge
                  if (!fast_sel) begin
                     s_nxt.pll_en = 1'b0;
                     s_nxt.pll_byp = 1'b1;
                     s_nxt.mclk_en = 1'b0;
                  end
               end else if (wait_req_i) begin
                  s_nxt.st = rsw_st_wait;
               end
            end
            rsw_st_wait: begin
               if (irq1_fall) begin
                  s_nxt.st = rsw_st_wake_w;
                  s_nxt.fast = fast_sel;
                  s_nxt.cnt = 5'h01;
                  s_nxt.et_cnt = 8'h00;
                  s_nxt.vec_done = 1'b0;
                  s_nxt.dm_done = 1'b0;
               end
            end
            rsw_st_wake_w: begin
               if (s_r.cnt != 5'h1f) begin
                  s_nxt.cnt = s_r.cnt + 5'h01;
               end
               if (et_tick && s_r.et_cnt != 8'hff) begin
                  s_nxt.et_cnt = s_r.et_cnt + 8'h01;
               end
               // vector address after 22 or 18 cycles
               if (!s_r.vec_done
                   && s_r.cnt == pick(s_r.fast, `RSW_VEC_FAST,
                                      `RSW_VEC_NORM)) begin
                  s_nxt.vec_fetch = 1'b1;
                  s_nxt.vec_pin = s_r.fetch_vis;
                  s_nxt.vec_done = 1'b1;
               end
               // data access after 18 cycles or 22 external
               if (!s_r.dm_done
                   && (s_r.fast ? s_r.cnt == `RSW_WDM_FAST
                                : s_r.et_cnt == `RSW_WDM_NORM_ET)) begin
                  s_nxt.dm_ok = 1'b1;
                  s_nxt.dm_done = 1'b1;
               end
               if (s_r.vec_done && s_r.dm_done) begin
                  s_nxt.st = rsw_st_run;
               end
            end
            rsw_st_stop: begin
               if (!ext_irq_first_n_i) begin
                  s_nxt.st = rsw_st_wake_s;
                  s_nxt.cnt = 5'h01;
                  // clock restarts, pll kept as stop left it: off and bypassed after a normal stop, as run set it from pll_on_req_i after a fast stop
                  s_nxt.mclk_en = 1'b1;
               end
            end
            rsw_st_wake_s: begin
               // data access after 2 cycles, one more if normal
               if (s_r.cnt == STOP_WAKE_CYC + {4'h0, !s_r.fast}) begin
                  s_nxt.dm_ok = 1'b1;
                  s_nxt.st = rsw_st_run;
               end else begin
                  s_nxt.cnt = s_r.cnt + 5'h01;
               end
            end
            default: begin
               s_nxt = RESET_VAL;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= RESET_VAL;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign core_reset_o        = s_r.core_rst;
   assign reset_out_pulse_n_o = s_r.reset_out_pulse_n;
   assign pll_enable_o        = s_r.pll_en;
   assign pll_bypass_o        = s_r.pll_byp;
   assign master_clk_en_o     = s_r.mclk_en;
   assign first_addr_o        = s_r.first_addr;
   assign svc_access_ok_o     = s_r.svc_ok;
   assign vector_fetch_o      = s_r.vec_fetch;
   assign vector_pin_o        = s_r.vec_pin;
   assign data_access_ok_o    = s_r.dm_ok;
   assign fetch_visible_o     = s_r.fetch_vis;

   ////////////////////////////////////////////////////////////////////////
   // checks
   localparam int A_RESET_OUT_PULSE_MIN = 8 * EXT_DIV - 1;
   logic [15:0] a_low_cnt;

   // cycles spent with the reset output low
   always_ff @(posedge clk_i) begin
      if (rst_i || s_r.reset_out_pulse_n) begin
         a_low_cnt <= 16'h0000;
      end else if (a_low_cnt != 16'hffff) begin
         a_low_cnt <= a_low_cnt + 16'h0001;
      end
   end

   sequence s_svc_quiet;
      (!svc_access_ok_o)[*8] ##1 (!svc_access_ok_o)[*6];
   endsequence

   sequence s_svc_due;
      ##[1:9] svc_access_ok_o;
   endsequence

   a_reset_pll_off: assert property (@(posedge clk_i) disable iff (rst_i)
      core_reset_o |-> pll_bypass_o && !pll_enable_o && master_clk_en_o)
      else $error("pll not bypassed in reset");

   a_first_addr_due: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(core_reset_o) |-> ##[0:120] first_addr_o)
      else $error("first address too late");

   a_reset_out_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(reset_out_pulse_n_o) |-> $past(a_low_cnt) >= A_RESET_OUT_PULSE_MIN)
      else $error("reset output pulse too short");

   // a board reset in mid count cancels the service access
   a_svc_latency: assert property (@(posedge clk_i)
      disable iff (rst_i || core_reset_o)
      $rose(s_r.svc_busy) |-> s_svc_quiet ##0 s_svc_due)
      else $error("service access latency wrong");

   a_wait_vector: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == rsw_st_wait && irq1_fall && !enter_rst)
      |=> (!vector_fetch_o)[*8] ##1 (!vector_fetch_o)[*8] ##[3:7]
          vector_fetch_o)
      else $error("wait wake vector latency wrong");

   a_stop_wake_dm: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == rsw_st_stop && !ext_irq_first_n_i && !enter_rst)
      |=> !data_access_ok_o ##1 !data_access_ok_o ##[1:2]
          data_access_ok_o)
      else $error("stop wake data access timing wrong");

   a_fast_stop_pll: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == rsw_st_stop && s_r.fast) |-> master_clk_en_o
      && pll_enable_o == $past(pll_enable_o))
      else $error("fast stop disturbed the clocks");

   a_normal_stop_clk: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_r.st == rsw_st_stop && !s_r.fast)
      |-> !master_clk_en_o && pll_bypass_o && !pll_enable_o)
      else $error("normal stop left clocks running");

   a_pin_fetch_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      vector_pin_o |-> vector_fetch_o && $past(fetch_visible_o))
      else $error("fetch shown outside mode 3");

   a_reset_release: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(core_reset_o) |-> $past(board_reset_n_i, 1)
      && reset_out_pulse_n_o)
      else $error("reset released while board reset low");

endmodule

// File: test/rsw_partner.sv
/* partner model: board reset source and the two interrupt requesters.
   assumes commands arrive from the bench at the falling clock edge. */
`timescale 1ns/10ps
module rsw_partner (
   input  wire logic       clk_i,
   input  wire logic [2:0] go_i,
   input  wire logic [7:0] len_i,
   output logic            board_reset_n_o,
   output logic            ext_irq_first_n_o,
   output logic            ext_irq_second_n_o
);
   // shortest low time per line: first irq, second irq, reset
   localparam logic [7:0] MIN_LO [3] = '{8'h02, 8'h02, 8'h07};
   logic [7:0]            cnt_r  [3] = '{8'h00, 8'h00, 8'h00};

   ////////////////////////////////////////////////////////////
   // lines held low at least the minimum
   always @(negedge clk_i) begin
      for (int i = 0; i < 3; i++) begin
         if (go_i[i]) begin
            cnt_r[i] <= (len_i < MIN_LO[i]) ? MIN_LO[i] : len_i;
         end else if (cnt_r[i] != 8'h00) begin
            cnt_r[i] <= cnt_r[i] - 8'h01;
         end
      end
   end

   // lines are pulled up, so a released line reads high
   assign ext_irq_first_n_o  = (cnt_r[0] == 8'h00);
   assign ext_irq_second_n_o = (cnt_r[1] == 8'h00);
   assign board_reset_n_o    = (cnt_r[2] == 8'h00);
endmodule

// File: test/rsw_seq_bench.sv
/* self-checking bench of the sequencer with random and corner cases.
   assumes the partner model drives the reset and interrupt lines. */
`timescale 1ns/10ps
module rsw_seq_bench;
   localparam int DIV = 2;
   logic        clk_i    = 1'b0;
   logic        rst_i    = 1'b1;
   logic        intm     = 1'b0;
   logic        stop_req = 1'b0;
   logic        wait_req = 1'b0;
   logic        pll_on   = 1'b0;
   logic        direct   = 1'b0;
   logic [15:0] operating_mode_reg      = 16'h0000;
   logic [1:0]  msel     = 2'h0;
   logic [2:0]  go       = 3'h0;
   logic [7:0]  len      = 8'h00;
   logic [31:0] seed     = 32'h00000062;
   logic [31:0] pick;
   logic        f;
   wire         brst_n, irq1_n, irq2_n, core_rst, reset_out_pulse_n, pll_en;
   wire         pll_byp, mclk_en, first_addr, svc_ok, vec, vec_pin;
   wire         dat_ok, fetch_vis;
   int          errors, compares, t_svc, t_vec, t_dat, t_pin;

   rsw_partner rsw_partner_inst (
      .clk_i              (clk_i),
      .go_i               (go),
      .len_i              (len),
      .board_reset_n_o    (brst_n),
      .ext_irq_first_n_o  (irq1_n),
      .ext_irq_second_n_o (irq2_n)
   );

   rsw_seq #(.FIRST_ADDR_CYC(8'h10), .EXT_DIV(DIV)) rsw_seq_inst (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .board_reset_n_i       (brst_n),
      .internal_reset_mode_i (intm),
      .ext_irq_first_n_i     (irq1_n),
      .ext_irq_second_n_i    (irq2_n),
      .stop_req_i            (stop_req),
      .wait_req_i            (wait_req),
      .pll_on_req_i          (pll_on),
      .ext_clk_direct_i      (direct),
      .operating_mode_reg_i  (operating_mode_reg),
      .mode_sel_i            (msel),
      .core_reset_o          (core_rst),
      .reset_out_pulse_n_o   (reset_out_pulse_n),
      .pll_enable_o          (pll_en),
      .pll_bypass_o          (pll_byp),
      .master_clk_en_o       (mclk_en),
      .first_addr_o          (first_addr),
      .svc_access_ok_o       (svc_ok),
      .vector_fetch_o        (vec),
      .vector_pin_o          (vec_pin),
      .data_access_ok_o      (dat_ok),
      .fetch_visible_o       (fetch_vis)
   );

   // 200 MHz core clock
   always #2.5 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////
   // xorshift source of repeatable random values
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // request a low pulse on partner lines, end just after edge k
   task automatic send(input logic [2:0] which, input logic [7:0] n);
      @(negedge clk_i);
      go  <= which;
      len <= n;
      @(negedge clk_i);
      go  <= 3'h0;
      @(posedge clk_i);
      #1;
   endtask

   // cycle of first appearance of each pulse after edge k
   task automatic watch(input int lim);
      t_svc = 0;
      t_vec = 0;
      t_dat = 0;
      t_pin = 0;
      for (int c = 1; c <= lim; c++) begin
         @(posedge clk_i);
         #1;
         if (svc_ok === 1'b1 && t_svc == 0) t_svc = c;
         if (vec === 1'b1 && t_vec == 0) t_vec = c;
         if (dat_ok === 1'b1 && t_dat == 0) t_dat = c;
         if (vec_pin === 1'b1 && t_pin == 0) t_pin = c;
      end
   endtask

   // follow one reset from entry to the first bus address
   task automatic boot(input int n_et, input int extra);
      int lo;
      int fa;
      lo = 1;
      fa = 0;
      check(pll_en, 1'b0);
      check(pll_byp, 1'b1);
      check(mclk_en, 1'b1);
      while (reset_out_pulse_n !== 1'b1 && lo < 4000) begin
         @(posedge clk_i);
         #1;
         lo++;
      end
      check(lo >= n_et * DIV && lo <= n_et * DIV + extra, 1'b1);
      check(core_rst, 1'b0);
      while (first_addr !== 1'b1 && fa < 200) begin
         @(posedge clk_i);
         #1;
         fa++;
      end
      check(fa, 17);
      @(posedge clk_i);
      #1;
      check(first_addr, 1'b0);
   endtask

   // verdict and end of run
   task automatic results();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      results();
   end

   // main sequence
   initial begin
      @(posedge clk_i);
      #1;
      fork
         begin
            repeat (20) @(negedge clk_i);
            rst_i <= 1'b0;
         end
         boot(128, 23);
      join
      $display("test reset done");
      // random service latency, either line, every fast source
      for (int i = 0; i < 8; i++) begin
         pick = rnd();
         f    = pick[0] | pick[1];
         @(negedge clk_i);
         direct <= pick[0];
         operating_mode_reg    <= {pick[31:23], pick[1], pick[21:16]};
         msel   <= pick[3:2];
         send({1'b0, pick[4], !pick[4]}, {5'h00, pick[7:5]});
         watch(24);
         check(t_svc, f ? 14 : 18);
         check(fetch_vis, msel == 2'h3);
      end
      $display("test service done");
      // wait wake, normal then fast, second line first
      for (int s = 0; s < 2; s++) begin
         f = s[0];
         @(negedge clk_i);
         direct   <= f;
         operating_mode_reg      <= 16'h0000;
         msel     <= f ? 2'h3 : 2'h1;
         wait_req <= 1'b1;
         @(negedge clk_i);
         wait_req <= 1'b0;
         send(3'h2, 8'h02);
         watch(30);
         check(t_vec, 0);
         send(3'h1, 8'h03);
         watch(60);
         check(t_vec, f ? 18 : 22);
         check(t_pin, f ? 18 : 0);
         check(t_dat >= (f ? 18 : 22 * DIV - 1), 1'b1);
         check(t_dat <= (f ? 18 : 22 * DIV + 1), 1'b1);
      end
      $display("test wait done");
      // stop wake, normal then fast through mode bit 6
      for (int s = 0; s < 2; s++) begin
         f = s[0];
         @(negedge clk_i);
         direct <= 1'b0;
         operating_mode_reg    <= f ? 16'h0040 : 16'h0000;
         pll_on <= 1'b1;
         repeat (3) @(negedge clk_i);
         check(pll_en, 1'b1);
         stop_req <= 1'b1;
         @(negedge clk_i);
         stop_req <= 1'b0;
         pll_on   <= 1'b0;
         @(negedge clk_i);
         check(mclk_en, f);
         check(pll_byp, !f);
         send(3'h1, 8'h04);
         check(mclk_en, 1'b1);
         check(pll_en, f);
         watch(8);
         check(t_dat, f ? 2 : 3);
         repeat (24) @(negedge clk_i);
      end
      $display("test stop done");
      // board reset in internal mode during a service count
      @(negedge clk_i);
      intm <= 1'b1;
      send(3'h1, 8'h02);
      send(3'h4, 8'h09);
      check(core_rst, 1'b1);
      check(reset_out_pulse_n, 1'b0);
      boot(8, 12);
      $display("test board reset done");
      results();
   end
endmodule
